/* src/fcr_map.vh */
// fcr_map.vh: opcodes, fixed counts and timing of the flash command interpreter
// assumes the includer runs on a 5 ns clock and counts cycles from these figures
`ifndef FCR_MAP_VH
`define FCR_MAP_VH

// opcodes
`define FCR_OP_WREN      8'h06
`define FCR_OP_WRDIS     8'h04
`define FCR_OP_RST_EN    8'h66
`define FCR_OP_RST_MEM   8'h99
`define FCR_OP_RD_FLAG   8'h70
`define FCR_OP_RD_LOCK4  8'hE0
`define FCR_OP_WR_LOCK4  8'hE1
`define FCR_OP_RD_DISC   8'h5A
`define FCR_OP_RD_GPR    8'h96
`define FCR_OP_FAST_RD   8'h0B
`define FCR_OP_QIO_RD    8'hEB
`define FCR_OP_WR_VCFG   8'h81
`define FCR_OP_EN_4B     8'hB7
`define FCR_OP_EX_4B     8'hE9
`define FCR_OP_WR_EXTA   8'hC5

// phase sizes
`define FCR_ADR_BYTES_3  3'd3
`define FCR_ADR_BYTES_4  3'd4
`define FCR_DUMMY_FIXED  5'd8
`define FCR_DUMMY_DEF    5'd8
`define FCR_GPR_BYTES    7'd64
`define FCR_DISC_WRAP    11'h7FF

// flag status layout
`define FCR_FSR_READY    7
`define FCR_FSR_ADDR4    0

// lock byte layout
`define FCR_LK_WRITE     0
`define FCR_LK_DOWN      1

// timing
`define FCR_CLK_NS       5
`define FCR_RECOV_NS     1000
`define FCR_RECOV_CYC    ((`FCR_RECOV_NS + `FCR_CLK_NS - 1) / `FCR_CLK_NS)

`endif

/* src/fcr_sync.v */
// fcr_sync.v: three-stage synchroniser for pin inputs
// assumes inputs are asynchronous to clk; a change passes once stages two and three agree
`default_nettype none

module fcr_sync #(
   parameter W = 6,
   parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
   // clock and reset
   input wire clk,
   input wire rst_n,
   // pins in, filtered level out
   input wire [W-1:0] async_in,
   output reg [W-1:0] sync_out
);

   reg [W-1:0] s1_q;
   reg [W-1:0] s2_q;
   reg [W-1:0] s3_q;

   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s1_q <= RST_VAL;
         s2_q <= RST_VAL;
         s3_q <= RST_VAL;
         sync_out <= RST_VAL;
      end
      else
      begin
         s1_q <= async_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
         // per bit: take the new level only where the last two stages agree
         sync_out <= (s3_q & ~(s2_q ^ s3_q)) | (sync_out & (s2_q ^ s3_q));
      end
   end

endmodule

`default_nettype wire

/* src/fcr_flash_cmd.v */
// fcr_flash_cmd.v: serial flash command interpreter with software reset
// assumes sclk and cs_n come from the host unsynchronised; core ports share clk
`default_nettype none
`include "fcr_map.vh"

module fcr_flash_cmd (
   // clock and reset
   input wire clk,
   input wire rst_n,
   // flash pins
   input wire sclk,
   input wire cs_n,
   input wire [3:0] io_i,
   output wire [3:0] io_o,
   output wire [3:0] io_oe,
   // active protocol
   input wire [1:0] proto,
   input wire dtr,
   // nonvolatile defaults
   input wire [3:0] nv_dummy,
   input wire nv_addr4,
   // core status
   input wire op_busy,
   input wire op_suspended,
   input wire cfg_wr_busy,
   // read port to the array and discovery table
   output wire [31:0] rd_addr,
   output wire rd_disc,
   input wire [7:0] rd_data,
   // general-purpose register load
   input wire gpr_we,
   input wire [5:0] gpr_idx,
   input wire [7:0] gpr_wdata,
   // state
   output wire wel,
   output wire addr4,
   output wire [3:0] dummy_cfg,
   output wire [7:0] ext_addr,
   output wire soft_rst_busy,
   output wire op_abort
);

   localparam [6:0] ST_IDLE = 7'h01;
   localparam [6:0] ST_OPC = 7'h02;
   localparam [6:0] ST_ADR = 7'h04;
   localparam [6:0] ST_DUM = 7'h08;
   localparam [6:0] ST_DIN = 7'h10;
   localparam [6:0] ST_DOUT = 7'h20;
   localparam [6:0] ST_WAIT = 7'h40;
   localparam integer RECOV_INT = `FCR_RECOV_CYC;
   localparam [11:0] RECOV_CYC = RECOV_INT[11:0];

   // line count of a protocol
   function [2:0] lines_of;
      input [1:0] p;
      begin
         case (p)
            2'd1: lines_of = 3'd2;
            2'd2: lines_of = 3'd4;
            default: lines_of = 3'd1;
         endcase
      end
   endfunction

   // shift w input lines into the low end
   function [31:0] shift_in;
      input [31:0] s;
      input [3:0] d;
      input [2:0] w;
      begin
         case (w)
            3'd1: shift_in = {s[30:0], d[0]};
            3'd2: shift_in = {s[29:0], d[1:0]};
            default: shift_in = {s[27:0], d};
         endcase
      end
   endfunction

   // top w bits of a byte placed on the output lines
   function [3:0] top_bits;
      input [7:0] b;
      input [2:0] w;
      begin
         case (w)
            3'd1: top_bits = {2'b00, b[7], 1'b0};
            3'd2: top_bits = {2'b00, b[7:6]};
            default: top_bits = b[7:4];
         endcase
      end
   endfunction

   function [3:0] oe_mask;
      input [2:0] w;
      begin
         case (w)
            3'd1: oe_mask = 4'h2;
            3'd2: oe_mask = 4'h3;
            default: oe_mask = 4'hF;
         endcase
      end
   endfunction

   function [2:0] adr_bytes;
      input [7:0] op;
      input a4;
      begin
         case (op)
            `FCR_OP_RD_LOCK4, `FCR_OP_WR_LOCK4: adr_bytes = `FCR_ADR_BYTES_4;
            `FCR_OP_RD_DISC: adr_bytes = `FCR_ADR_BYTES_3;
            `FCR_OP_FAST_RD, `FCR_OP_QIO_RD:
               adr_bytes = a4 ? `FCR_ADR_BYTES_4 : `FCR_ADR_BYTES_3;
            default: adr_bytes = 3'd0;
         endcase
      end
   endfunction

   function [4:0] dummy_of;
      input [7:0] op;
      input [3:0] cfg;
      begin
         case (op)
            `FCR_OP_RD_DISC, `FCR_OP_RD_GPR: dummy_of = `FCR_DUMMY_FIXED;
            `FCR_OP_FAST_RD, `FCR_OP_QIO_RD:
               dummy_of = (cfg == 4'h0) ? `FCR_DUMMY_DEF : {1'b0, cfg};
            default: dummy_of = 5'd0;
         endcase
      end
   endfunction

   function is_read;
      input [7:0] op;
      begin
         is_read = (op == `FCR_OP_RD_FLAG) || (op == `FCR_OP_RD_LOCK4) ||
            (op == `FCR_OP_RD_DISC) || (op == `FCR_OP_RD_GPR) ||
            (op == `FCR_OP_FAST_RD) || (op == `FCR_OP_QIO_RD);
      end
   endfunction

   function is_wprot;
      input [7:0] op;
      begin
         is_wprot = (op == `FCR_OP_WR_LOCK4) || (op == `FCR_OP_WR_VCFG) ||
            (op == `FCR_OP_WR_EXTA);
      end
   endfunction

   function is_known;
      input [7:0] op;
      begin
         is_known = is_read(op) || is_wprot(op) || (op == `FCR_OP_WREN) ||
            (op == `FCR_OP_WRDIS) || (op == `FCR_OP_RST_EN) ||
            (op == `FCR_OP_RST_MEM) || (op == `FCR_OP_EN_4B) || (op == `FCR_OP_EX_4B);
      end
   endfunction

   // state that follows the address phase
   function [6:0] after_adr;
      input [7:0] op;
      input [3:0] cfg;
      begin
         if (dummy_of(op, cfg) != 5'd0)
            after_adr = ST_DUM;
         else if (is_read(op))
            after_adr = ST_DOUT;
         else if (is_wprot(op))
            after_adr = ST_DIN;
         else
            after_adr = ST_WAIT;
      end
   endfunction

   // pin synchronisers
   wire [5:0] pins_s;
   fcr_sync #(.W(6), .RST_VAL(6'h10)) u_sync (
      .clk(clk),
      .rst_n(rst_n),
      .async_in({sclk, cs_n, io_i}),
      .sync_out(pins_s)
   );

   wire sclk_s = pins_s[5];
   wire cs_s = pins_s[4];
   wire [3:0] io_s = pins_s[3:0];

   reg sclk_q;
   reg cs_q;
   reg [6:0] st_q;
   reg [7:0] opc_q;
   reg [31:0] sh_q;
   reg [5:0] bitn_q;
   reg [5:0] need_q;
   reg [2:0] aw_q;
   reg [4:0] dcnt_q;
   reg [31:0] adr_q;
   reg [31:0] rd_addr_q;
   reg rd_disc_q;
   reg [7:0] din_q;
   reg [7:0] ob_q;
   reg [3:0] obits_q;
   reg [6:0] idx_q;
   reg [3:0] io_o_q;
   reg [3:0] io_oe_q;
   reg wel_q;
   reg pend_q;
   reg addr4_q;
   reg [3:0] dummy_q;
   reg [7:0] ext_q;
   reg [11:0] rcnt_q;
   reg init_q;
   reg abort_q;
   reg [1:0] lk_q [0:1023];
   reg [7:0] gpr_q [0:63];
   integer i;

   wire rise = sclk_s & ~sclk_q;
   wire fall = ~sclk_s & sclk_q;
   wire rbusy = (rcnt_q != 12'd0);
   wire sel_start = ~cs_s & cs_q & ~rbusy;
   wire sel_end = cs_s & ~cs_q;
   // double transfer rate samples on both edges, outputs likewise
   wire cap_ev = rise | (dtr & fall);
   wire out_ev = fall | (dtr & rise);
   wire [2:0] pw = lines_of(proto);
   wire [2:0] cur_w = (st_q == ST_OPC) ? pw : aw_q;
   wire [31:0] shn = shift_in(sh_q, io_s, cur_w);
   wire [5:0] bitn_n = bitn_q + {3'b000, cur_w};
   wire [7:0] nop = shn[7:0];
   wire [9:0] sect = adr_q[25:16];
   wire done_cmd = sel_end & (st_q == ST_WAIT);
   wire start_rst = done_cmd & (opc_q == `FCR_OP_RST_MEM) & pend_q;
   wire restore = init_q | start_rst;
   wire lk_wr = done_cmd & (opc_q == `FCR_OP_WR_LOCK4) & ~lk_q[sect][`FCR_LK_DOWN];

   // byte to send next
   reg [7:0] nb;
   always @*
   begin
      nb = 8'h00;
      case (opc_q)
         `FCR_OP_RD_FLAG:
         begin
            nb[`FCR_FSR_READY] = ~op_busy;
            nb[`FCR_FSR_ADDR4] = addr4_q;
         end
         `FCR_OP_RD_LOCK4: nb = {6'h00, lk_q[sect]};
         `FCR_OP_RD_GPR: nb = (idx_q < `FCR_GPR_BYTES) ? gpr_q[idx_q[5:0]] : 8'h00;
         default: nb = rd_data;
      endcase
   end

   // general-purpose register contents from the core
   always @(posedge clk)
   begin
      if (gpr_we)
         gpr_q[gpr_idx] <= gpr_wdata;
   end

   // volatile lock bits; cleared on any reset
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         for (i = 0; i < 1024; i = i + 1)
            lk_q[i] <= 2'b00;
      end
      else if (restore)
      begin
         for (i = 0; i < 1024; i = i + 1)
            lk_q[i] <= 2'b00;
      end
      else if (lk_wr)
         lk_q[sect] <= din_q[1:0];
   end

   // configuration, write enable and software reset
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wel_q <= 1'b0;
         pend_q <= 1'b0;
         addr4_q <= 1'b0;
         dummy_q <= 4'h0;
         ext_q <= 8'h00;
         rcnt_q <= 12'd0;
         init_q <= 1'b1;
         abort_q <= 1'b0;
      end
      else
      begin
         init_q <= 1'b0;
         abort_q <= start_rst & (op_busy | op_suspended);
         if (rbusy)
            rcnt_q <= rcnt_q - 12'd1;
         if (restore)
         begin
            // reload volatile state from nonvolatile defaults
            wel_q <= 1'b0;
            pend_q <= 1'b0;
            addr4_q <= nv_addr4;
            dummy_q <= nv_dummy;
            ext_q <= 8'h00;
            if (start_rst)
               rcnt_q <= RECOV_CYC;
         end
         else if (sel_end && !(st_q == ST_OPC && bitn_q == 6'd0))
         begin
            // any finished command other than reset enable drops the pending reset
            pend_q <= done_cmd & (opc_q == `FCR_OP_RST_EN);
            if (done_cmd)
            begin
               case (opc_q)
                  `FCR_OP_WREN: wel_q <= 1'b1;
                  `FCR_OP_WRDIS: wel_q <= 1'b0;
                  `FCR_OP_EN_4B: addr4_q <= 1'b1;
                  `FCR_OP_EX_4B: addr4_q <= 1'b0;
                  `FCR_OP_WR_VCFG: dummy_q <= din_q[7:4];
                  `FCR_OP_WR_EXTA: ext_q <= din_q;
                  default: wel_q <= wel_q;
               endcase
               if (is_wprot(opc_q))
                  wel_q <= 1'b0;
            end
         end
      end
   end

   // frame state machine
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sclk_q <= 1'b0;
         cs_q <= 1'b1;
         st_q <= ST_IDLE;
         opc_q <= 8'h00;
         sh_q <= 32'h0;
         bitn_q <= 6'd0;
         need_q <= 6'd8;
         aw_q <= 3'd1;
         dcnt_q <= 5'd0;
         adr_q <= 32'h0;
         rd_addr_q <= 32'h0;
         rd_disc_q <= 1'b0;
         din_q <= 8'h00;
         ob_q <= 8'h00;
         obits_q <= 4'd0;
         idx_q <= 7'd0;
         io_o_q <= 4'h0;
         io_oe_q <= 4'h0;
      end
      else
      begin
         sclk_q <= sclk_s;
         cs_q <= cs_s;
         if (sel_end || rbusy)
         begin
            st_q <= ST_IDLE;
            io_oe_q <= 4'h0;
         end
         else if (sel_start)
         begin
            st_q <= ST_OPC;
            bitn_q <= 6'd0;
            need_q <= 6'd8;
            obits_q <= 4'd0;
            idx_q <= 7'd0;
         end
         else if (!cs_s)
         begin
            case (st_q)
               ST_OPC, ST_ADR, ST_DIN:
                  if (cap_ev)
                  begin
                     sh_q <= shn;
                     bitn_q <= bitn_n;
                     if (bitn_n == need_q)
                     begin
                        bitn_q <= 6'd0;
                        need_q <= 6'd8;
                        if (st_q == ST_OPC)
                        begin
                           opc_q <= nop;
                           dcnt_q <= dummy_of(nop, dummy_q);
                           aw_q <= (nop == `FCR_OP_QIO_RD) ? 3'd4 : pw;
                           if (!is_known(nop) ||
                              (nop == `FCR_OP_RST_EN && cfg_wr_busy) ||
                              (is_wprot(nop) && !wel_q))
                              st_q <= ST_IDLE;
                           else if (adr_bytes(nop, addr4_q) != 3'd0)
                           begin
                              st_q <= ST_ADR;
                              need_q <= {adr_bytes(nop, addr4_q), 3'b000};
                           end
                           else
                              st_q <= after_adr(nop, dummy_q);
                        end
                        else if (st_q == ST_ADR)
                        begin
                           adr_q <= shn;
                           rd_disc_q <= (opc_q == `FCR_OP_RD_DISC);
                           if (opc_q == `FCR_OP_RD_DISC)
                              rd_addr_q <= {8'h00, shn[23:0]};
                           else
                              rd_addr_q <= addr4_q ? shn : {ext_q, shn[23:0]};
                           st_q <= after_adr(opc_q, dummy_q);
                        end
                        else
                        begin
                           din_q <= shn[7:0];
                           st_q <= ST_WAIT;
                        end
                     end
                  end
               ST_DUM:
                  // dummy clocks are counted on rising edges only
                  if (rise)
                  begin
                     dcnt_q <= dcnt_q - 5'd1;
                     if (dcnt_q == 5'd1)
                        st_q <= ST_DOUT;
                  end
               ST_DOUT:
                  if (out_ev)
                  begin
                     io_oe_q <= oe_mask(aw_q);
                     if (obits_q == 4'd0)
                     begin
                        io_o_q <= top_bits(nb, aw_q);
                        ob_q <= nb << aw_q;
                        obits_q <= 4'd8 - {1'b0, aw_q};
                        if (idx_q != `FCR_GPR_BYTES)
                           idx_q <= idx_q + 7'd1;
                        if (rd_disc_q)
                           rd_addr_q[10:0] <= (rd_addr_q[10:0] + 11'd1) & `FCR_DISC_WRAP;
                        else
                           rd_addr_q <= rd_addr_q + 32'd1;
                     end
                     else
                     begin
                        io_o_q <= top_bits(ob_q, aw_q);
                        ob_q <= ob_q << aw_q;
                        obits_q <= obits_q - {1'b0, aw_q};
                     end
                  end
               ST_WAIT:
                  st_q <= ST_WAIT;
               default:
                  st_q <= ST_IDLE;
            endcase
         end
      end
   end

   assign io_o = io_o_q;
   assign io_oe = io_oe_q;
   assign rd_addr = rd_addr_q;
   assign rd_disc = rd_disc_q;
   assign wel = wel_q;
   assign addr4 = addr4_q;
   assign dummy_cfg = dummy_q;
   assign ext_addr = ext_q;
   assign soft_rst_busy = rbusy;
   assign op_abort = abort_q;

endmodule

`default_nettype wire

/* tb/fcr_checker.sv */
// fcr_checker.sv: port assertions for the flash command interpreter
// assumes a bind onto fcr_flash_cmd; one clock domain
`default_nettype none
module fcr_checker (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // pins, core status and nonvolatile defaults
   input wire logic cs_n,
   input wire logic [3:0] io_oe,
   input wire logic op_busy,
   input wire logic op_suspended,
   input wire logic nv_addr4,
   input wire logic [3:0] nv_dummy,
   // state
   input wire logic wel,
   input wire logic addr4,
   input wire logic [3:0] dummy_cfg,
   input wire logic [7:0] ext_addr,
   input wire logic soft_rst_busy,
   input wire logic op_abort
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int RECOV = 200;
   logic [8:0] busy_cnt_q;
   always_ff @(posedge clk or negedge rst_n)
      if (!rst_n) busy_cnt_q <= 9'h000;
      else busy_cnt_q <= soft_rst_busy ? busy_cnt_q + 9'h001 : 9'h000;
   default clocking @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   chk_oe_legal: assert property (io_oe inside {4'h0, 4'h2, 4'h3, 4'hF})
      else $error("output enable pattern not legal");
   chk_oe_idle: assert property (cs_n [*8] |-> io_oe == 4'h0)
      else $error("outputs driven while deselected");
   chk_busy_quiet: assert property (soft_rst_busy && $past(soft_rst_busy) |-> io_oe == 4'h0 && !wel)
      else $error("device active during recovery");
   chk_busy_len: assert property ($fell(soft_rst_busy) |-> busy_cnt_q == RECOV)
      else $error("recovery length wrong");
   chk_rst_reload: assert property ($rose(soft_rst_busy) |-> !wel && ext_addr == 8'h00
      && addr4 == nv_addr4 && dummy_cfg == nv_dummy)
      else $error("state not reloaded on soft reset");
   chk_rst_deselect: assert property ($rose(soft_rst_busy) |-> cs_n)
      else $error("soft reset started while selected");
   chk_abort_cause: assert property (op_abort |-> soft_rst_busy && (op_busy || op_suspended))
      else $error("abort without reset of a running operation");
   chk_abort_pulse: assert property (op_abort |=> !op_abort)
      else $error("abort longer than one cycle");
   chk_abort_given: assert property ($rose(soft_rst_busy) && (op_busy || op_suspended)
      |-> ##[0:1] op_abort)
      else $error("running operation not aborted");
   chk_cfg_deselect: assert property (!$stable(ext_addr) || !$stable(addr4) |-> cs_n)
      else $error("configuration changed mid frame");
   cov_abort: cover property (op_abort);
   cov_reset: cover property ($rose(soft_rst_busy));
   cov_quad: cover property (io_oe == 4'hF);
   cov_dual: cover property (io_oe == 4'h3);
endmodule
`default_nettype wire

/* tb/fcr_host_model.sv */
// fcr_host_model.sv: behavioural host controller on the flash pins
// assumes the bench calls cmd() and reads rq; sclk idles low
`default_nettype none
module fcr_host_model (
   // pins to the device
   output var logic sclk,
   output var logic cs_n,
   output var logic [3:0] io_i,
   // pins from the device
   input wire logic [3:0] io_o,
   input wire logic [3:0] io_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int GAP_NS = 120; // reset_deselect_gap, kept after every frame
   logic [7:0] rq[$];
   initial
   begin
      sclk = 1'b0;
      cs_n = 1'b1;
      io_i = 4'h5;
   end
   // released lines carry inverted data so stale values never match
   task automatic bits(input logic [7:0] b, input int n, input int cnt, input bit rel,
                       output logic [7:0] r);
      logic [7:0] v;
      logic [3:0] w;
      v = b;
      r = 8'h00;
      repeat (cnt)
      begin
         #10;
         if (rel) io_i = ~io_i;
         else for (int k = 0; k < n; k++) io_i[n-1-k] = v[7-k];
         v = v << n;
         #14 sclk = 1'b1;
         #24;
         w = (io_oe & io_o) | (~io_oe & ~io_i);
         for (int k = 0; k < n; k++) r = {r[6:0], n == 1 ? w[1] : w[n-1-k]};
         sclk = 1'b0;
      end
   endtask
   // double transfer rate opcode: one group of bits per sclk edge, ends with sclk low
   task automatic dtr_op(input logic [7:0] b, input int n);
      cs_n = 1'b0;
      for (int e = 0; e < 8 / n; e++)
      begin
         #10;
         for (int k = 0; k < n; k++) io_i[n-1-k] = b[7-e*n-k];
         #14 sclk = ~sclk;
      end
      #10 cs_n = 1'b1;
      io_i = ~io_i;
      #(GAP_NS);
   endtask
   task automatic cmd(input logic [7:0] op, input int ol, input logic [31:0] a, input int na,
                      input int al, input int nd, input logic [7:0] wd, input int nw,
                      input int nr);
      logic [7:0] r;
      rq.delete();
      cs_n = 1'b0;
      bits(op, ol, 8 / ol, 1'b0, r);
      for (int i = na - 1; i >= 0; i--) bits(a[8*i +: 8], al, 8 / al, 1'b0, r);
      bits(8'h00, 1, nd, 1'b1, r);
      if (nw != 0) bits(wd, al, 8 / al, 1'b0, r);
      repeat (nr)
      begin
         bits(8'h00, al, 8 / al, 1'b1, r);
         rq.push_back(r);
      end
      #10 cs_n = 1'b1;
      io_i = ~io_i;
      #(GAP_NS);
   endtask
endmodule
`default_nettype wire

/* tb/fcr_flash_cmd_tb_top.sv */
// fcr_flash_cmd_tb_top.sv: self-checking bench for the flash command interpreter
// assumes fcr_map.vh on the include path; host model drives the pins
`default_nettype none
`include "fcr_map.vh"
module fcr_flash_cmd_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic sclk, cs_n, rd_disc, wel, addr4, soft_rst_busy, op_abort;
   logic dtr = 1'b0;
   logic nv_addr4 = 1'b0;
   logic op_busy = 1'b0;
   logic op_susp = 1'b0;
   logic cfg_wr_busy = 1'b0;
   logic gpr_we = 1'b0;
   logic [5:0] gpr_idx = 6'h00;
   logic [7:0] gpr_wdata = 8'h00;
   logic [1:0] proto = 2'h0;
   logic [3:0] nv_dummy = 4'h0;
   logic [3:0] io_i, io_o, io_oe, dummy_cfg;
   logic [7:0] rd_data, ext_addr, x;
   logic [31:0] rd_addr, a;
   logic [7:0] gpr[64];
   int n_fail = 0;
   int compares = 0;
   int n_abort = 0;
   int cyc = 0;
   always #2.5 clk = ~clk;
   function automatic logic [7:0] fdat(input logic [31:0] ad, input logic disc);
      return ad[7:0] ^ ad[23:16] ^ ad[31:24] ^ {disc, 7'h00};
   endfunction
   function automatic int dum(input logic [3:0] d);
      return d == 4'h0 ? 8 : int'(d);
   endfunction
   assign rd_data = fdat(rd_addr, rd_disc);
   fcr_host_model host_u (.sclk(sclk), .cs_n(cs_n), .io_i(io_i), .io_o(io_o), .io_oe(io_oe));
   fcr_flash_cmd dut_u (.clk(clk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .io_i(io_i),
      .io_o(io_o), .io_oe(io_oe), .proto(proto), .dtr(dtr), .nv_dummy(nv_dummy),
      .nv_addr4(nv_addr4), .op_busy(op_busy), .op_suspended(op_susp),
      .cfg_wr_busy(cfg_wr_busy), .rd_addr(rd_addr), .rd_disc(rd_disc), .rd_data(rd_data),
      .gpr_we(gpr_we), .gpr_idx(gpr_idx), .gpr_wdata(gpr_wdata), .wel(wel), .addr4(addr4),
      .dummy_cfg(dummy_cfg), .ext_addr(ext_addr), .soft_rst_busy(soft_rst_busy),
      .op_abort(op_abort));
   task automatic close_out();
      $display("compares %0d, mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   always @(posedge clk)
   begin
      if (op_abort === 1'b1) n_abort++;
      cyc++;
      if (cyc == 80000)
      begin
         n_fail++;
         close_out();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         n_fail++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic c(input logic [7:0] op, input int ol, input logic [31:0] ad, input int na,
                    input int al, input int nd, input logic [7:0] wd, input int nw,
                    input int nr);
      host_u.cmd(op, ol, ad, na, al, nd, wd, nw, nr);
      tick(1);
   endtask
   // recovery wait, bounded
   task automatic wait_idle();
      for (int i = 0; i < 400 && soft_rst_busy !== 1'b0; i++) tick(1);
      chk(soft_rst_busy, 1'b0);
   endtask
   initial
   begin
      a = $urandom(92553);
      nv_dummy = 4'($urandom);
      nv_addr4 = 1'($urandom);
      tick(6);
      rst_n = 1'b1;
      tick(4);
      chk(addr4, nv_addr4);
      chk(dummy_cfg, nv_dummy);
      chk(wel, 1'b0);
      $display("test defaults done");
      for (int p = 0; p < 3; p++)
      begin
         proto = 2'(p);
         op_busy = 1'($urandom);
         c(`FCR_OP_RD_FLAG, 1 << p, 0, 0, 1 << p, 0, 0, 0, 2);
         chk(host_u.rq[1] & 8'h81, {~op_busy, 6'h00, nv_addr4});
      end
      proto = 2'h0;
      op_busy = 1'b0;
      $display("test protocols done");
      c(`FCR_OP_EX_4B, 1, 0, 0, 1, 0, 0, 0, 0);
      a = $urandom & 32'h00FFFFFF;
      c(`FCR_OP_FAST_RD, 1, a, 3, 1, dum(nv_dummy), 0, 0, 1);
      chk(host_u.rq[0], fdat(a, 1'b0));
      c(`FCR_OP_EN_4B, 1, 0, 0, 1, 0, 0, 0, 0);
      a = $urandom & 32'h03FFFFFF;
      c(`FCR_OP_QIO_RD, 1, a, 4, 4, dum(nv_dummy), 0, 0, 1);
      chk(host_u.rq[0], fdat(a, 1'b0));
      a = $urandom & 32'h000007FF;
      c(`FCR_OP_RD_DISC, 1, a, 3, 1, 8, 0, 0, 1);
      chk(host_u.rq[0], fdat(a, 1'b1));
      $display("test addressing done");
      a = $urandom & 32'h03FF0000;
      c(`FCR_OP_WR_LOCK4, 1, a, 4, 1, 0, 8'h01, 1, 0);
      c(`FCR_OP_RD_LOCK4, 1, a, 4, 1, 0, 0, 0, 1);
      chk(host_u.rq[0], 8'h00);
      c(`FCR_OP_WREN, 1, 0, 0, 1, 0, 0, 0, 0);
      x = 8'($urandom_range(3, 1));
      c(`FCR_OP_WR_LOCK4, 1, a, 4, 1, 0, x, 1, 0);
      c(`FCR_OP_RD_LOCK4, 1, a, 4, 1, 0, 0, 0, 3);
      chk(host_u.rq[0], x);
      chk(host_u.rq[2], x);
      $display("test locks done");
      for (int i = 0; i < 64; i++)
      begin
         gpr[i] = 8'($urandom);
         gpr_we = 1'b1;
         gpr_idx = 6'(i);
         gpr_wdata = gpr[i];
         tick(1);
      end
      gpr_we = 1'b0;
      c(`FCR_OP_RD_GPR, 1, 0, 0, 1, 8, 0, 0, 66);
      for (int i = 0; i < 66; i++) chk(host_u.rq[i], i < 64 ? gpr[i] : 8'h00);
      $display("test gpr done");
      x = 8'($urandom_range(255, 1));
      c(`FCR_OP_WREN, 1, 0, 0, 1, 0, 0, 0, 0);
      c(`FCR_OP_WR_EXTA, 1, 0, 0, 1, 0, x, 1, 0);
      chk(ext_addr, x);
      c(`FCR_OP_WREN, 1, 0, 0, 1, 0, 0, 0, 0);
      c(`FCR_OP_WR_VCFG, 1, 0, 0, 1, 0, 8'hA0, 1, 0);
      chk(dummy_cfg, 4'hA);
      // the model never enters execute_in_place before the reset pair
      op_busy = 1'b1;
      c(`FCR_OP_RST_EN, 1, 0, 0, 1, 0, 0, 0, 0);
      c(`FCR_OP_RST_MEM, 1, 0, 0, 1, 0, 0, 0, 0);
      chk(soft_rst_busy, 1'b1);
      chk({wel, addr4, dummy_cfg, ext_addr}, {1'b0, nv_addr4, nv_dummy, 8'h00});
      chk(n_abort, 1);
      op_busy = 1'b0;
      wait_idle();
      c(`FCR_OP_RD_LOCK4, 1, a, 4, 1, 0, 0, 0, 1);
      chk(host_u.rq[0], 8'h00);
      c(`FCR_OP_RD_FLAG, 1, 0, 0, 1, 0, 0, 0, 1);
      chk(host_u.rq[0][7], 1'b1);
      $display("test reset done");
      c(`FCR_OP_RST_EN, 1, 0, 0, 1, 0, 0, 0, 0);
      c(`FCR_OP_WREN, 1, 0, 0, 1, 0, 0, 0, 0);
      c(`FCR_OP_RST_MEM, 1, 0, 0, 1, 0, 0, 0, 0);
      chk({soft_rst_busy, wel}, 2'h1);
      cfg_wr_busy = 1'b1;
      c(`FCR_OP_RST_EN, 1, 0, 0, 1, 0, 0, 0, 0);
      cfg_wr_busy = 1'b0;
      c(`FCR_OP_RST_MEM, 1, 0, 0, 1, 0, 0, 0, 0);
      chk(soft_rst_busy, 1'b0);
      proto = 2'h2;
      op_susp = 1'b1;
      c(`FCR_OP_RST_EN, 4, 0, 0, 4, 0, 0, 0, 0);
      c(`FCR_OP_RST_MEM, 4, 0, 0, 4, 0, 0, 0, 0);
      chk(soft_rst_busy, 1'b1);
      chk(n_abort, 2);
      op_susp = 1'b0;
      wait_idle();
      proto = 2'h1;
      dtr = 1'b1;
      host_u.dtr_op(`FCR_OP_RST_EN, 2);
      host_u.dtr_op(`FCR_OP_RST_MEM, 2);
      tick(1);
      chk(soft_rst_busy, 1'b1);
      dtr = 1'b0;
      wait_idle();
      $display("test reset refusals done");
      close_out();
   end
endmodule
bind fcr_flash_cmd fcr_checker chk_u (.clk(clk), .rst_n(rst_n), .cs_n(cs_n), .io_oe(io_oe),
   .op_busy(op_busy), .op_suspended(op_suspended), .nv_addr4(nv_addr4),
   .nv_dummy(nv_dummy), .wel(wel), .addr4(addr4), .dummy_cfg(dummy_cfg),
   .ext_addr(ext_addr), .soft_rst_busy(soft_rst_busy), .op_abort(op_abort));
`default_nettype wire
